/* File: logic/sas_pkg.sv */
// Purpose: Shared constants and carrier types for the vector architectural state block
// Assumes: Big-endian bit numbering of the control word maps bit n to index 31-n
// Notes: Element layouts cover bytes, halfwords and words of one vector
package sas_pkg;
  localparam int SAS_VEC_W = 128;
  localparam int SAS_NUM_REGS = 32;
  localparam int SAS_IDX_W = 5;
  localparam int SAS_CTL_W = 32;
  localparam int SAS_NUM_TAGS = 4;
  localparam int SAS_TAG_W = 2;
  // Control word positions, little-endian index of printed bits 15 and 31
  localparam int SAS_MODE_POS = 16;
  localparam int SAS_CLAMP_POS = 0;
  localparam logic [31:0] SAS_CTL_RESET = 32'h0000_0000;
  localparam logic [31:0] SAS_CTL_DEF_MASK = 32'h0001_0001;
  localparam logic [127:0] SAS_VEC_RESET = 128'h0;
  localparam logic SAS_ENABLE_RESET = 1'b0;
  localparam logic [3:0] SAS_CR6_RESET = 4'h0;
  localparam int SAS_FP_CYCLES_FAST = 4;
  localparam int SAS_FP_CYCLES_STRICT = 5;
  localparam int SAS_FWD_CYCLE = 4;
  localparam logic [2:0] SAS_CNT_W3_ONE = 3'h1;

  typedef enum logic [1:0] {
    SAS_ELEM_BYTE = 2'h0,
    SAS_ELEM_HALF = 2'h1,
    SAS_ELEM_WORD = 2'h2
  } sas_elem_type;

  typedef enum logic [2:0] {
    SAS_UNIT_PERM = 3'h1,
    SAS_UNIT_ALU = 3'h2,
    SAS_UNIT_FLOAT = 3'h4
  } sas_unit_type;

  typedef struct packed {
    logic valid;
    logic supervisor;
    sas_unit_type unit;
    logic [SAS_IDX_W-1:0] src_a;
    logic [SAS_IDX_W-1:0] dst;
    logic wr_en;
    logic [127:0] result;
    logic saturated;
    logic is_compare;
    logic record_flag;
    logic all_true;
    logic all_false;
    logic move_to_ctl;
    logic move_from_ctl;
  } sas_op_type;

  typedef struct packed {
    logic valid;
    logic set_enable;
    logic enable_val;
    logic supervisor;
  } sas_msr_type;
endpackage

/* File: logic/sas_flush.sv */
// Purpose: Denormal and underflow flushing of four single-precision lanes
// Assumes: Lanes are IEEE single format, lane 0 in the low word
// Notes: Pass-through in strict mode; sign is kept on every flushed lane
`timescale 1ns/100ps
module sas_flush
  import sas_pkg::*;
(
  input wire logic non_ieee_mode_in,
  input wire logic [127:0] vec_in,
  input wire logic [3:0] underflow_in,
  output logic [127:0] vec_out
);
  function automatic logic [31:0] sas_zero_keep_sign(input logic [31:0] w, input logic force_z);
    logic denorm;
    denorm = (w[30:23] == 8'h00) && (w[22:0] != 23'h0);
    if (denorm || force_z) begin
      sas_zero_keep_sign = {w[31], 31'h0};
    end else begin
      sas_zero_keep_sign = w;
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      // Strict mode leaves denormals untouched
      assign vec_out[32*g+:32] = non_ieee_mode_in ?
          sas_zero_keep_sign(vec_in[32*g+:32], underflow_in[g]) : vec_in[32*g+:32];
    end
  endgenerate
endmodule

/* File: logic/sas_state.sv */
// Purpose: Vector register file, enable bit, compare field and status/control word
// Assumes: Pipeline presents one retiring vector op per cycle with result computed
// Notes: Read ports are combinational; writes land on the next edge
`timescale 1ns/100ps
// Summary of operation
// - Every vector path carries a full 128-bit operand.
// - Separate permute and arithmetic/logic subunits take their own ops.
// - Stream touch supports four independent stream tags, load and store forms.
// - No user thread-management special registers are implemented.
// - Recorded vector compares update condition field 6, user mode allowed.
// - Enable bit resets to zero; only supervisor machine-state write sets it.
// - Register file holds 32 vector registers for load, store, compute.
// - Each register is 128 bits, viewed as bytes, halfwords or words.
// - Control word is 32 bits, reached only by vector instructions.
// - Move-from/move-to copy control word via low bits of a vector.
// - Only mode bit 15 and saturation bit 31 are defined.
// - Reserved bits may be written; reads return zero.
// - Bit 15 selects strict or fast floating-point mode.
// - Strict mode handles denormals per IEEE without flushing.
// - Fast mode replaces denormal float results with signed zero.
// - Fast mode writes underflowing results as signed zero.
// - Saturation bit is sticky until a move-to clears it.
// - Any saturating element in saturating ops sets the saturation bit.
// - Strict mode adds one float cycle; forwarding stays at cycle four.
module sas_state
  import sas_pkg::*;
#(
  parameter int NUM_REGS = SAS_NUM_REGS,
  parameter int NUM_TAGS = SAS_NUM_TAGS
)
(
  input wire logic CLK_SYS_IN,
  input wire logic RSTN_IN,
  input wire sas_op_type OP_IN,
  input wire logic [3:0] UNDERFLOW_IN,
  input wire sas_msr_type MSR_WR_IN,
  input wire logic [SAS_IDX_W-1:0] RD_A_IDX_IN,
  input wire logic [SAS_IDX_W-1:0] RD_B_IDX_IN,
  input wire sas_elem_type RD_ELEM_IN,
  input wire logic [3:0] RD_LANE_IN,
  input wire logic STREAM_START_IN,
  input wire logic STREAM_STOP_IN,
  input wire logic STREAM_STOP_ALL_IN,
  input wire logic STREAM_STORE_IN,
  input wire logic [SAS_TAG_W-1:0] STREAM_TAG_IN,
  input wire logic SPR_ACCESS_IN,
  output logic [127:0] RD_A_OUT,
  output logic [127:0] RD_B_OUT,
  output logic [31:0] RD_ELEM_OUT,
  output logic SIMD_ENABLE_OUT,
  output logic [3:0] CONDITION_REG_F6_OUT,
  output logic [31:0] VECTOR_STATUS_CONTROL_OUT,
  output logic NON_IEEE_MODE_OUT,
  output logic [2:0] FP_EXEC_CYCLES_OUT,
  output logic [2:0] FP_FWD_CYCLE_OUT,
  output logic UNAVAILABLE_EXC_OUT,
  output logic ILLEGAL_SPR_OUT,
  output logic PERM_ISSUE_OUT,
  output logic ALU_ISSUE_OUT,
  output logic [NUM_TAGS-1:0] STREAM_ACTIVE_OUT,
  output logic [NUM_TAGS-1:0] STREAM_STORE_OUT
);
  logic [127:0] vrf_q [NUM_REGS];
  logic simd_enable_q;
  logic [3:0] cr6_q;
  logic non_ieee_mode_q;
  logic clamp_sticky_q;
  logic unavail_q;
  logic illegal_spr_q;
  logic perm_issue_q;
  logic alu_issue_q;
  logic [NUM_TAGS-1:0] stream_act_q;
  logic [NUM_TAGS-1:0] stream_st_q;

  wire logic op_go = OP_IN.valid && simd_enable_q;
  wire logic op_blocked = OP_IN.valid && !simd_enable_q;
  wire logic stream_blocked = (STREAM_START_IN || STREAM_STOP_IN || STREAM_STOP_ALL_IN) &&
      !simd_enable_q;
  // Printed bit 31 lands on index 0 and bit 15 on index 16, matching the package mask
  wire logic [31:0] ctl_word = {15'h0, non_ieee_mode_q, 15'h0, clamp_sticky_q};
  wire logic [127:0] src_low_word = vrf_q[OP_IN.src_a];
  wire logic is_float = (OP_IN.unit == SAS_UNIT_FLOAT);
  wire logic [127:0] flushed;
  // Move-from places the control word in the low word of the target
  wire logic [127:0] wr_data = OP_IN.move_from_ctl ? {96'h0, ctl_word} :
      (is_float ? flushed : OP_IN.result);
  wire logic wr_go = op_go && (OP_IN.wr_en || OP_IN.move_from_ctl);
  wire logic msr_set_ok = MSR_WR_IN.valid && MSR_WR_IN.supervisor;
  wire logic clamp_set = op_go && OP_IN.saturated;
  wire logic ctl_load = op_go && OP_IN.move_to_ctl;
  wire logic cr6_load = op_go && OP_IN.is_compare && OP_IN.record_flag;
  wire logic [3:0] cr6_val = {OP_IN.all_true, 1'b0, OP_IN.all_false, 1'b0};

  function automatic logic [31:0] sas_elem_pick(input logic [127:0] v, input sas_elem_type e,
      input logic [3:0] lane);
    sas_elem_pick = 32'h0;
    case (e)
      SAS_ELEM_BYTE: sas_elem_pick = {24'h0, v[8*lane+:8]};
      SAS_ELEM_HALF: sas_elem_pick = {16'h0, v[16*lane[2:0]+:16]};
      SAS_ELEM_WORD: sas_elem_pick = v[32*lane[1:0]+:32];
      default: sas_elem_pick = 32'h0;
    endcase
  endfunction

  sas_flush u_flush (
    .non_ieee_mode_in(non_ieee_mode_q),
    .vec_in(OP_IN.result),
    .underflow_in(UNDERFLOW_IN),
    .vec_out(flushed)
  );

  // Register file, full width writes
  always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        vrf_q[i] <= SAS_VEC_RESET;
      end
    end else if (wr_go) begin
      vrf_q[OP_IN.dst] <= wr_data;
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      simd_enable_q <= SAS_ENABLE_RESET;
    end else if (msr_set_ok) begin
      simd_enable_q <= MSR_WR_IN.enable_val;
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      cr6_q <= SAS_CR6_RESET;
    end else if (cr6_load) begin
      cr6_q <= cr6_val;
    end
  end

  // Reserved bits are never stored, so they read zero
  always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      non_ieee_mode_q <= SAS_CTL_RESET[SAS_MODE_POS];
      clamp_sticky_q <= SAS_CTL_RESET[SAS_CLAMP_POS];
    end else begin
      if (ctl_load) begin
        non_ieee_mode_q <= src_low_word[SAS_MODE_POS];
      end
      // Set beats a clearing move in the same cycle
      if (clamp_set) begin
        clamp_sticky_q <= 1'b1;
      end else if (ctl_load) begin
        clamp_sticky_q <= src_low_word[SAS_CLAMP_POS];
      end
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      unavail_q <= 1'b0;
      illegal_spr_q <= 1'b0;
      perm_issue_q <= 1'b0;
      alu_issue_q <= 1'b0;
    end else begin
      unavail_q <= op_blocked || stream_blocked;
      // Control word and thread registers have no special-register path
      illegal_spr_q <= SPR_ACCESS_IN;
      perm_issue_q <= op_go && (OP_IN.unit == SAS_UNIT_PERM);
      alu_issue_q <= op_go && (OP_IN.unit != SAS_UNIT_PERM);
    end
  end

  // Four stream tags tracked independently
  always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      stream_act_q <= '0;
      stream_st_q <= '0;
    end else if (simd_enable_q) begin
      if (STREAM_STOP_ALL_IN) begin
        stream_act_q <= '0;
      end else if (STREAM_STOP_IN) begin
        stream_act_q[STREAM_TAG_IN] <= 1'b0;
      end else if (STREAM_START_IN) begin
        stream_act_q[STREAM_TAG_IN] <= 1'b1;
        stream_st_q[STREAM_TAG_IN] <= STREAM_STORE_IN;
      end
    end
  end

  assign RD_A_OUT = vrf_q[RD_A_IDX_IN];
  assign RD_B_OUT = vrf_q[RD_B_IDX_IN];
  assign RD_ELEM_OUT = sas_elem_pick(vrf_q[RD_A_IDX_IN], RD_ELEM_IN, RD_LANE_IN);
  assign SIMD_ENABLE_OUT = simd_enable_q;
  assign CONDITION_REG_F6_OUT = cr6_q;
  assign VECTOR_STATUS_CONTROL_OUT = ctl_word & SAS_CTL_DEF_MASK;
  assign NON_IEEE_MODE_OUT = non_ieee_mode_q;
  // Strict mode costs a cycle but forwarding point is unchanged
  assign FP_EXEC_CYCLES_OUT = non_ieee_mode_q ? 3'(SAS_FP_CYCLES_FAST) : 3'(SAS_FP_CYCLES_STRICT);
  assign FP_FWD_CYCLE_OUT = 3'(SAS_FWD_CYCLE);
  assign UNAVAILABLE_EXC_OUT = unavail_q;
  assign ILLEGAL_SPR_OUT = illegal_spr_q;
  assign PERM_ISSUE_OUT = perm_issue_q;
  assign ALU_ISSUE_OUT = alu_issue_q;
  assign STREAM_ACTIVE_OUT = stream_act_q;
  assign STREAM_STORE_OUT = stream_st_q;
endmodule

/* File: testbench/sas_pipe_model.sv */
// Purpose: Dispatch pipeline model presenting retiring vector ops
// Assumes: One op per call, valid for exactly one cycle
// Notes: Released fields show the inverse so stale data never reads as live
`timescale 1ns/100ps
module sas_pipe_model
  import sas_pkg::*;
(
  input wire logic clk_in,
  output sas_op_type op_out,
  output logic [3:0] uf_out
);
  initial begin
    op_out = '0;
    uf_out = 4'h0;
  end
  // Whole 128-bit result in one beat
  task send(input sas_op_type o, input logic [3:0] u);
    @(posedge clk_in);
    #1;
    op_out = o;
    uf_out = u;
    @(posedge clk_in);
    #1;
    op_out = {1'b0, ~o[$bits(sas_op_type)-2:0]};
    uf_out = ~u;
  endtask
endmodule

/* File: testbench/sas_state_assertions.sv */
// Purpose: Port-level checks of the vector state block
// Assumes: Single clock domain, asynchronous low reset
// Notes: Attached by bind at the foot of this file
`timescale 1ns/100ps
module sas_state_assertions
  import sas_pkg::*;
(
  input wire logic CLK_SYS_IN,
  input wire logic RSTN_IN,
  input wire sas_op_type OP_IN,
  input wire sas_msr_type MSR_WR_IN,
  input wire logic SPR_ACCESS_IN,
  input wire logic SIMD_ENABLE_OUT,
  input wire logic [3:0] CONDITION_REG_F6_OUT,
  input wire logic [31:0] VECTOR_STATUS_CONTROL_OUT,
  input wire logic NON_IEEE_MODE_OUT,
  input wire logic [2:0] FP_EXEC_CYCLES_OUT,
  input wire logic [2:0] FP_FWD_CYCLE_OUT,
  input wire logic UNAVAILABLE_EXC_OUT,
  input wire logic ILLEGAL_SPR_OUT
);
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RSTN_IN);
  wire [31:0] vsc = VECTOR_STATUS_CONTROL_OUT;
  wire go = OP_IN.valid && SIMD_ENABLE_OUT;
  property p_resv; (vsc & ~SAS_CTL_DEF_MASK) == 32'h0; endproperty
  a_resv: assert property (p_resv) else $error("reserved bit set");
  property p_mode; NON_IEEE_MODE_OUT == vsc[SAS_MODE_POS]; endproperty
  a_mode: assert property (p_mode) else $error("mode out mismatch");
  property p_fp;
    FP_EXEC_CYCLES_OUT == (NON_IEEE_MODE_OUT ? 3'h4 : 3'h5) && FP_FWD_CYCLE_OUT == 3'h4;
  endproperty
  a_fp: assert property (p_fp) else $error("float cycle count wrong");
  property p_unav;
    OP_IN.valid && !SIMD_ENABLE_OUT |=> UNAVAILABLE_EXC_OUT && $stable(vsc);
  endproperty
  a_unav: assert property (p_unav) else $error("blocked op not refused");
  property p_spr; SPR_ACCESS_IN |=> ILLEGAL_SPR_OUT; endproperty
  a_spr: assert property (p_spr) else $error("special move not refused");
  property p_en;
    !SIMD_ENABLE_OUT && !(MSR_WR_IN.valid && MSR_WR_IN.supervisor) |=> !SIMD_ENABLE_OUT;
  endproperty
  a_en: assert property (p_en) else $error("enable set without supervisor");
  property p_keep;
    vsc[SAS_CLAMP_POS] && !(go && OP_IN.move_to_ctl) |=> vsc[SAS_CLAMP_POS];
  endproperty
  a_keep: assert property (p_keep) else $error("sticky bit lost");
  property p_sat; go && OP_IN.saturated |=> vsc[SAS_CLAMP_POS]; endproperty
  a_sat: assert property (p_sat) else $error("saturation not recorded");
  property p_cr6; go && OP_IN.is_compare && OP_IN.record_flag |=>
    CONDITION_REG_F6_OUT == {$past(OP_IN.all_true), 1'b0, $past(OP_IN.all_false), 1'b0};
  endproperty
  a_cr6: assert property (p_cr6) else $error("compare field wrong");
  c_en: cover property ($rose(SIMD_ENABLE_OUT));
  c_sat: cover property (go && OP_IN.saturated);
  c_nj: cover property ($rose(NON_IEEE_MODE_OUT));
endmodule
bind sas_state sas_state_assertions u_sas_state_assertions (.CLK_SYS_IN(CLK_SYS_IN),
  .RSTN_IN(RSTN_IN), .OP_IN(OP_IN), .MSR_WR_IN(MSR_WR_IN), .SPR_ACCESS_IN(SPR_ACCESS_IN),
  .SIMD_ENABLE_OUT(SIMD_ENABLE_OUT), .CONDITION_REG_F6_OUT(CONDITION_REG_F6_OUT),
  .VECTOR_STATUS_CONTROL_OUT(VECTOR_STATUS_CONTROL_OUT), .NON_IEEE_MODE_OUT(NON_IEEE_MODE_OUT),
  .FP_EXEC_CYCLES_OUT(FP_EXEC_CYCLES_OUT), .FP_FWD_CYCLE_OUT(FP_FWD_CYCLE_OUT),
  .UNAVAILABLE_EXC_OUT(UNAVAILABLE_EXC_OUT), .ILLEGAL_SPR_OUT(ILLEGAL_SPR_OUT));

/* File: testbench/sas_state_tb.sv */
// Purpose: Self-checking bench for the vector state block
// Assumes: Pipeline model issues one op per call
// Notes: Seeded random register data plus corner cases
`timescale 1ns/100ps
module sas_state_tb
  import sas_pkg::*;
();
  logic clk = 0, rstn = 0, ss = 0, sp = 0, sa = 0, st = 0, special_purpose_reg = 0;
  logic [1:0] tag = 0;
  logic [4:0] ia = 0, ib = 0;
  logic [3:0] lane = 0, uf, cr6, act, sto;
  sas_elem_type ek = SAS_ELEM_BYTE;
  sas_msr_type machine_state_reg = '0;
  sas_op_type op;
  logic [127:0] ra, rb, v, mem [32];
  logic [31:0] re, vsc, r;
  logic [2:0] fpx, fpf;
  logic en, nj, unav, ill, pi, ai;
  logic [6:0] sf [5] = '{7'h02, 7'h40, 7'h00, 7'h42, 7'h02};
  logic [4:0] se = 5'b01110;
  logic [6:0] cf [3] = '{7'h38, 7'h24, 7'h34};
  logic [3:0] ce [3] = '{4'h8, 4'h8, 4'h2};
  int errors = 0, compares = 0, cyc = 0;
  always #20 clk = ~clk;
  sas_pipe_model u_sas_pipe_model (.clk_in(clk), .op_out(op), .uf_out(uf));
  sas_state u_sas_state (.CLK_SYS_IN(clk), .RSTN_IN(rstn), .OP_IN(op), .UNDERFLOW_IN(uf),
    .MSR_WR_IN(machine_state_reg), .RD_A_IDX_IN(ia), .RD_B_IDX_IN(ib), .RD_ELEM_IN(ek), .RD_LANE_IN(lane),
    .STREAM_START_IN(ss), .STREAM_STOP_IN(sp), .STREAM_STOP_ALL_IN(sa), .STREAM_STORE_IN(st),
    .STREAM_TAG_IN(tag), .SPR_ACCESS_IN(special_purpose_reg), .RD_A_OUT(ra), .RD_B_OUT(rb), .RD_ELEM_OUT(re),
    .SIMD_ENABLE_OUT(en), .CONDITION_REG_F6_OUT(cr6), .VECTOR_STATUS_CONTROL_OUT(vsc),
    .NON_IEEE_MODE_OUT(nj), .FP_EXEC_CYCLES_OUT(fpx), .FP_FWD_CYCLE_OUT(fpf),
    .UNAVAILABLE_EXC_OUT(unav), .ILLEGAL_SPR_OUT(ill), .PERM_ISSUE_OUT(pi), .ALU_ISSUE_OUT(ai),
    .STREAM_ACTIVE_OUT(act), .STREAM_STORE_OUT(sto));
  function automatic logic [31:0] el(input logic [127:0] x, input sas_elem_type k,
    input logic [3:0] l);
    if (k == SAS_ELEM_BYTE) el = {24'h0, x[l*8+:8]};
    else if (k == SAS_ELEM_HALF) el = {16'h0, x[l[2:0]*16+:16]};
    else el = x[l[1:0]*32+:32];
  endfunction
  // Signed zero for denormal or underflowed lanes
  function automatic logic [127:0] fl(input logic [127:0] x, input logic [3:0] u);
    logic [31:0] w;
    fl = x;
    for (int i = 0; i < 4; i++) begin
      w = x[i*32+:32];
      if (u[i] || (w[30:23] == 8'h00 && w[22:0] != 23'h0)) fl[i*32+:32] = {w[31], 31'h0};
    end
  endfunction
  task cmp_v(input logic [127:0] g, input logic [127:0] e);
    compares++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t vector %h exp %h", $time, g, e);
    end
  endtask
  task cmp_f(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t flags %h exp %h", $time, g, e);
    end
  endtask
  task tick;
    @(posedge clk);
    #1;
  endtask
  task issue(input sas_unit_type u, input logic [4:0] s, d, input logic w,
    input logic [127:0] x, input logic [6:0] f, input logic [3:0] fu);
    u_sas_pipe_model.send({2'b10, u, s, d, w, x, f}, fu);
  endtask
  task setm(input logic s, input logic val);
    tick;
    machine_state_reg = {2'b10, val, s};
    tick;
    machine_state_reg = {1'b0, ~machine_state_reg[2:0]};
  endtask
  task pls(input logic [4:0] f, input logic [1:0] t);
    tick;
    {special_purpose_reg, ss, sp, sa, st} = f;
    tag = t;
    tick;
    {special_purpose_reg, ss, sp, sa, st} = 5'h00;
  endtask
  task done(input string s);
    $display("test %s done", s);
  endtask
  task tally_and_finish;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      tally_and_finish;
    end
  end
  initial begin
    r = $urandom(32'hEDA9);
    repeat (8) @(posedge clk);
    #1;
    rstn = 1;
    cmp_f({en, nj, fpx, fpf}, {2'b00, 3'h5, 3'h4});
    cmp_f(vsc, SAS_CTL_RESET);
    ia = 5'h3;
    issue(SAS_UNIT_ALU, 5'h0, 5'h3, 1'b1, '1, 7'h40, 4'h0);
    cmp_f({unav, ai}, 2'b10);
    cmp_f(vsc, SAS_CTL_RESET);
    cmp_v(ra, 128'h0);
    pls(5'h08, 2'h0);
    cmp_f(act, 4'h0);
    setm(1'b0, 1'b1);
    cmp_f(en, 1'b0);
    setm(1'b1, 1'b1);
    cmp_f(en, 1'b1);
    done("enable");
    for (int i = 0; i < 32; i++) begin
      mem[i] = {$urandom, $urandom, $urandom, $urandom};
      issue(i[0] ? SAS_UNIT_PERM : SAS_UNIT_ALU, 5'h0, i[4:0], 1'b1, mem[i], 7'h00, 4'h0);
      cmp_f({pi, ai}, {i[0], ~i[0]});
    end
    for (int i = 0; i < 32; i++) begin
      ia = i[4:0];
      ib = ~i[4:0];
      ek = sas_elem_type'(2'($urandom % 3));
      lane = 4'($urandom);
      tick;
      cmp_v(ra, mem[i]);
      cmp_v(rb, mem[31-i]);
      cmp_f(re, el(mem[i], ek, lane));
    end
    done("regfile");
    v = {$urandom, $urandom, $urandom, $urandom} | 128'h1_0001;
    issue(SAS_UNIT_ALU, 5'h0, 5'h7, 1'b1, v, 7'h00, 4'h0);
    issue(SAS_UNIT_ALU, 5'h7, 5'h0, 1'b0, '0, 7'h02, 4'h0);
    cmp_f(vsc, 32'h0001_0001);
    cmp_f({nj, fpx, fpf}, {1'b1, 3'h4, 3'h4});
    ia = 5'h9;
    issue(SAS_UNIT_ALU, 5'h0, 5'h9, 1'b1, '1, 7'h01, 4'h0);
    cmp_v(ra, {96'h0, 32'h0001_0001});
    issue(SAS_UNIT_ALU, 5'h0, 5'h8, 1'b1, v ^ 128'h1, 7'h00, 4'h0);
    for (int i = 0; i < 5; i++) begin
      issue(SAS_UNIT_ALU, 5'h8, 5'hA, 1'b1, v, sf[i], 4'h0);
      cmp_f(vsc, {16'h0001, 15'h0, se[i]});
    end
    done("control");
    v = {32'h8000_0001, 32'hBF80_0000, 32'h0000_0005, 32'h4000_0000};
    ia = 5'hB;
    issue(SAS_UNIT_FLOAT, 5'h0, 5'hB, 1'b1, v, 7'h00, 4'h4);
    cmp_v(ra, fl(v, 4'h4));
    issue(SAS_UNIT_ALU, 5'h0, 5'hC, 1'b1, '0, 7'h00, 4'h0);
    issue(SAS_UNIT_ALU, 5'hC, 5'h0, 1'b0, '0, 7'h02, 4'h0);
    cmp_f({nj, fpx}, {1'b0, 3'h5});
    issue(SAS_UNIT_FLOAT, 5'h0, 5'hB, 1'b1, v, 7'h00, 4'h0);
    cmp_v(ra, v);
    for (int i = 0; i < 3; i++) begin
      issue(SAS_UNIT_ALU, 5'h0, 5'h0, 1'b0, '0, cf[i], 4'h0);
      cmp_f(cr6, ce[i]);
    end
    done("float and compare");
    for (int t = 0; t < 4; t++) pls({4'h4, t[0]}, 2'(t));
    cmp_f({act, sto}, 8'hFA);
    pls(5'h04, 2'h1);
    cmp_f(act, 4'hD);
    pls(5'h02, 2'h0);
    cmp_f(act, 4'h0);
    pls(5'h10, 2'h0);
    cmp_f(ill, 1'b1);
    done("streams");
    tally_and_finish;
  end
endmodule
